//--- verilog/seq_defs.svh
// constants for the extended and relative bus-cycle sequencer
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
`define SEQ_RESET_ADDR 16'h0000
`define SEQ_NIB_ALU    4'h0
`define SEQ_NIB_LD16   4'h1
`define SEQ_NIB_STA    4'h2
`define SEQ_NIB_STSX   4'h3
`define SEQ_NIB_RMW    4'h4
`define SEQ_NIB_TST    4'h5
`define SEQ_NIB_JMP    4'h6
`define SEQ_NIB_JSR    4'h7
`define SEQ_NIB_BR     4'h8
`define SEQ_NIB_BSR    4'h9
`define SEQ_COND_ALWAYS 4'h0
`define SEQ_CYC_ALU    4'h4
`define SEQ_CYC_LD16   4'h5
`define SEQ_CYC_STA    4'h5
`define SEQ_CYC_STSX   4'h6
`define SEQ_CYC_RMW    4'h6
`define SEQ_CYC_JMP    4'h3
`define SEQ_CYC_JSR    4'h9
`define SEQ_CYC_BR     4'h4
`define SEQ_CYC_BSR    4'h8
`define SEQ_CYC_NONE   4'h1
`define SEQ_LEN_EXT    16'h0003
`define SEQ_LEN_REL    16'h0002
`define SEQ_LEN_NONE   16'h0001
`endif

//--- verilog/seq_pkg.sv
// types shared by the bus-cycle sequencer
package seq_pkg;
  typedef enum logic [3:0] {
    ROLE_IRRELEVANT, ROLE_OPCODE, ROLE_ADDR_HI, ROLE_ADDR_LO,
    ROLE_OFFSET, ROLE_OPERAND, ROLE_OPER_HI, ROLE_OPER_LO,
    ROLE_NEXT_OP, ROLE_RET_LO, ROLE_RET_HI, ROLE_ACC,
    ROLE_REG_HI, ROLE_REG_LO, ROLE_NEW_OPERAND
  } byte_role_type;

  typedef enum logic [3:0] {
    GRP_NONE, GRP_ALU, GRP_LD16, GRP_STA, GRP_STSX, GRP_RMW,
    GRP_TST, GRP_JMP, GRP_JSR, GRP_BR, GRP_BSR
  } instr_group_type;

  typedef struct packed {
    logic [15:0]   addr;
    logic          valid_address_strobe;
    logic          rw;
    logic [7:0]    dout;
    logic          doe;
    byte_role_type role;
  } bus_cycle_type;
endpackage

//--- verilog/extended_relative_bus_sequencer.sv
// bus-cycle sequencer for extended and relative addressing
`timescale 1ns/10ps
`include "seq_defs.svh"

//Contract
// - store stack/index: six cycles, high then low
// - call: nine cycles, three valid fetches
// - call cycle four reads subroutine start
// - call cycles five, six push return address
// - call cycles seven, eight invalid; nine reads
// - jump: three valid fetch cycles
// - single-byte ops: four valid read cycles
// - 16-bit loads: five valid read cycles
// - accumulator store: invalid cycle, then write
// - read-modify-write: read, invalid, write back
// - test operand: final write cycle invalid
// - relative branch: four cycles, two invalid
// - branch to subroutine: eight cycles
// - branch to subroutine pushes, four invalid
module extended_relative_bus_sequencer
(
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST_B,
  input  wire logic [7:0]            DATA_IN,
  input  wire logic                  COND_TRUE,
  input  wire logic [7:0]            ACC_DATA,
  input  wire logic [15:0]           STACK_PTR,
  input  wire logic [15:0]           INDEX_REG,
  input  wire logic [7:0]            NEW_OPERAND,
  output seq_pkg::bus_cycle_type     BUS
);
  import seq_pkg::*;

  bus_cycle_type   bus_q;
  bus_cycle_type   bus_d;
  logic [3:0]      cyc_q;
  logic [3:0]      cyc_d;
  instr_group_type grp_q;
  instr_group_type grp_w;
  logic [7:0]      op_q;
  logic [7:0]      op_w;
  logic [15:0]     op_addr_q;
  logic [15:0]     op_addr_d;
  logic [15:0]     ea_q;
  logic [15:0]     ea_w;
  logic [15:0]     br_tgt;
  logic            last;
  logic            ext;

  function automatic instr_group_type decode(input logic [7:0] op);
    case (op[7:4])
      `SEQ_NIB_ALU:  decode = GRP_ALU;
      `SEQ_NIB_LD16: decode = GRP_LD16;
      `SEQ_NIB_STA:  decode = GRP_STA;
      `SEQ_NIB_STSX: decode = GRP_STSX;
      `SEQ_NIB_RMW:  decode = GRP_RMW;
      `SEQ_NIB_TST:  decode = GRP_TST;
      `SEQ_NIB_JMP:  decode = GRP_JMP;
      `SEQ_NIB_JSR:  decode = GRP_JSR;
      `SEQ_NIB_BR:   decode = GRP_BR;
      `SEQ_NIB_BSR:  decode = GRP_BSR;
      default:       decode = GRP_NONE;
    endcase
  endfunction

  function automatic logic [3:0] cycles(input instr_group_type g);
    case (g)
      GRP_ALU:          cycles = `SEQ_CYC_ALU;
      GRP_LD16:         cycles = `SEQ_CYC_LD16;
      GRP_STA:          cycles = `SEQ_CYC_STA;
      GRP_STSX:         cycles = `SEQ_CYC_STSX;
      GRP_RMW, GRP_TST: cycles = `SEQ_CYC_RMW;
      GRP_JMP:          cycles = `SEQ_CYC_JMP;
      GRP_JSR:          cycles = `SEQ_CYC_JSR;
      GRP_BR:           cycles = `SEQ_CYC_BR;
      GRP_BSR:          cycles = `SEQ_CYC_BSR;
      default:          cycles = `SEQ_CYC_NONE;
    endcase
  endfunction

  function automatic logic is_ext(input instr_group_type g);
    is_ext = !(g == GRP_BR || g == GRP_BSR || g == GRP_NONE);
  endfunction

  // one bus cycle of an instruction, cycles counted from 1
  function automatic bus_cycle_type cycle_for(
    input instr_group_type g,
    input logic [3:0]      n,
    input logic [15:0]     pc,
    input logic [15:0]     ea,
    input logic [15:0]     tgt,
    input logic [15:0]     reg16
  );
    bus_cycle_type c;
    logic [15:0]   ret;
    c = '0;
    c.addr = pc;
    c.valid_address_strobe = 1'b1;
    c.rw = 1'b1;
    c.role = ROLE_OPCODE;
    ret = (g == GRP_JSR) ? pc + `SEQ_LEN_EXT : pc + `SEQ_LEN_REL;
    if (n == 4'h2)
    begin
      c.addr = pc + 16'h0001;
      c.role = is_ext(g) ? ROLE_ADDR_HI : ROLE_OFFSET;
    end
    else if (n == 4'h3 && is_ext(g))
    begin
      c.addr = pc + 16'h0002;
      c.role = ROLE_ADDR_LO;
    end
    else if (n >= 4'h3)
    begin
      c.addr = ea;
      c.role = ROLE_IRRELEVANT;
      case (g)
        GRP_ALU:
          c.role = ROLE_OPERAND;
        GRP_LD16:
        begin
          c.addr = (n == 4'h5) ? ea + 16'h0001 : ea;
          c.role = (n == 4'h5) ? ROLE_OPER_LO : ROLE_OPER_HI;
        end
        GRP_STA:
        begin
          c.valid_address_strobe = (n == 4'h5);
          c.rw = (n != 4'h5);
          c.dout = ACC_DATA;
          c.role = (n == 4'h5) ? ROLE_ACC : ROLE_IRRELEVANT;
        end
        GRP_STSX:
        begin
          c.valid_address_strobe = (n != 4'h4);
          c.rw = (n == 4'h4);
          c.addr = (n == 4'h6) ? ea + 16'h0001 : ea;
          c.dout = (n == 4'h6) ? reg16[7:0] : reg16[15:8];
          if (n != 4'h4)
            c.role = (n == 4'h6) ? ROLE_REG_LO : ROLE_REG_HI;
        end
        GRP_RMW, GRP_TST:
        begin
          // memory must not see the write for a test, so strobe stays low
          c.valid_address_strobe = (n == 4'h4) || (n == 4'h6 && g == GRP_RMW);
          c.rw = (n != 4'h6);
          c.dout = NEW_OPERAND;
          if (n == 4'h4)
            c.role = ROLE_OPERAND;
          else if (n == 4'h6 && g == GRP_RMW)
            c.role = ROLE_NEW_OPERAND;
        end
        GRP_JSR:
        begin
          case (n)
            4'h4: c.role = ROLE_NEXT_OP;
            4'h5:
            begin
              c.addr = STACK_PTR;
              c.rw = 1'b0;
              c.dout = ret[7:0];
              c.role = ROLE_RET_LO;
            end
            4'h6:
            begin
              c.addr = STACK_PTR - 16'h0001;
              c.rw = 1'b0;
              c.dout = ret[15:8];
              c.role = ROLE_RET_HI;
            end
            4'h7:
            begin
              c.addr = STACK_PTR - 16'h0002;
              c.valid_address_strobe = 1'b0;
            end
            4'h8:
            begin
              c.addr = pc + 16'h0002;
              c.valid_address_strobe = 1'b0;
            end
            default:
            begin
              c.addr = pc + 16'h0002;
              c.role = ROLE_ADDR_LO;
            end
          endcase
        end
        GRP_BR:
        begin
          c.valid_address_strobe = 1'b0;
          c.addr = (n == 4'h3) ? pc + 16'h0002 : tgt;
        end
        GRP_BSR:
        begin
          c.valid_address_strobe = (n == 4'h4 || n == 4'h5);
          c.rw = !c.valid_address_strobe;
          case (n)
            4'h3, 4'h7: c.addr = ret;
            4'h4: c.addr = STACK_PTR;
            4'h5: c.addr = STACK_PTR - 16'h0001;
            4'h6: c.addr = STACK_PTR - 16'h0002;
            default: c.addr = tgt;
          endcase
          c.dout = (n == 4'h4) ? ret[7:0] : ret[15:8];
          if (n == 4'h4)
            c.role = ROLE_RET_LO;
          else if (n == 4'h5)
            c.role = ROLE_RET_HI;
        end
        default:
          c.valid_address_strobe = 1'b0;
      endcase
    end
    c.doe = !c.rw;
    return c;
  endfunction

  // bytes read this cycle are merged before the next cycle is planned
  always_comb
  begin
    op_w = (cyc_q == 4'h1) ? DATA_IN : op_q;
    grp_w = (cyc_q == 4'h1) ? decode(DATA_IN) : grp_q;
    ext = is_ext(grp_w);
    ea_w = ea_q;
    if (cyc_q == 4'h2)
      ea_w = ext ? {DATA_IN, ea_q[7:0]} : {8'h00, DATA_IN};
    else if (cyc_q == 4'h3 && ext)
      ea_w = {ea_q[15:8], DATA_IN};
    br_tgt = op_addr_q + `SEQ_LEN_REL + {{8{ea_q[7]}}, ea_q[7:0]};
    last = (cyc_q >= cycles(grp_w));
  end

  always_comb
  begin
    op_addr_d = op_addr_q;
    cyc_d = cyc_q + 4'h1;
    if (last)
    begin
      cyc_d = 4'h1;
      case (grp_w)
        GRP_JMP, GRP_JSR: op_addr_d = ea_w;
        GRP_BSR: op_addr_d = br_tgt;
        GRP_BR:
          // branch condition is sampled only in the final cycle
          op_addr_d = (op_w[3:0] == `SEQ_COND_ALWAYS || COND_TRUE) ? br_tgt
                      : op_addr_q + `SEQ_LEN_REL;
        GRP_NONE: op_addr_d = op_addr_q + `SEQ_LEN_NONE;
        default: op_addr_d = op_addr_q + `SEQ_LEN_EXT;
      endcase
    end
    bus_d = cycle_for(grp_w, cyc_d, op_addr_d, ea_w, br_tgt,
                      op_w[0] ? INDEX_REG : STACK_PTR);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      bus_q <= '0;
      bus_q.addr <= `SEQ_RESET_ADDR;
      bus_q.valid_address_strobe <= 1'b1;
      bus_q.rw <= 1'b1;
      bus_q.role <= ROLE_OPCODE;
    end
    else
      bus_q <= bus_d;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
      cyc_q <= 4'h1;
    else
      cyc_q <= cyc_d;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      grp_q <= GRP_NONE;
      op_q <= 8'h00;
    end
    else
    begin
      grp_q <= grp_w;
      op_q <= op_w;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      op_addr_q <= `SEQ_RESET_ADDR;
      ea_q <= 16'h0000;
    end
    else
    begin
      op_addr_q <= op_addr_d;
      ea_q <= ea_w;
    end
  end

  assign BUS = bus_q;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  sequence invalid_read;
    !bus_q.valid_address_strobe && bus_q.rw;
  endsequence
  sequence valid_write;
    bus_q.valid_address_strobe && !bus_q.rw && bus_q.doe;
  endsequence
  sequence new_opcode;
    bus_q.role == ROLE_OPCODE && bus_q.valid_address_strobe && bus_q.rw;
  endsequence

  chk_store_reg_order: assert property (
    grp_q == GRP_STSX && cyc_q == 4'h4 |-> invalid_read ##1
    (valid_write and bus_q.addr == $past(bus_q.addr)) ##1
    (valid_write and bus_q.addr == $past(bus_q.addr) + 16'h0001) ##1 new_opcode)
    else $error("store of stack or index out of order");
  chk_call_fetch: assert property (
    grp_q == GRP_JSR && cyc_q == 4'h2 |->
    bus_q.valid_address_strobe && bus_q.addr == op_addr_q + 16'h0001 ##1
    bus_q.valid_address_strobe && bus_q.addr == op_addr_q + 16'h0002)
    else $error("call address fetch wrong");
  chk_call_target_read: assert property (
    grp_q == GRP_JSR && cyc_q == 4'h4 |-> bus_q.valid_address_strobe && bus_q.rw && bus_q.addr == ea_q)
    else $error("call start read wrong");
  chk_call_push: assert property (
    grp_q == GRP_JSR && cyc_q == 4'h5 |-> (valid_write and bus_q.addr == STACK_PTR
    && bus_q.dout == op_addr_q[7:0] + 8'h03))
    else $error("call push of return low wrong");
  chk_call_tail: assert property (
    grp_q == GRP_JSR && cyc_q == 4'h7 |-> invalid_read ##1 invalid_read ##1
    (bus_q.valid_address_strobe && bus_q.addr == op_addr_q + 16'h0002) ##1 new_opcode)
    else $error("call tail cycles wrong");
  chk_jump_target: assert property (
    grp_q == GRP_JMP && cyc_q == 4'h3 |=> (new_opcode and bus_q.addr == $past(ea_w)))
    else $error("jump target wrong");
  chk_alu_next: assert property (
    grp_q == GRP_ALU && cyc_q == 4'h4 |-> bus_q.valid_address_strobe && bus_q.addr == ea_q ##1
    (new_opcode and bus_q.addr == $past(op_addr_q) + 16'h0003))
    else $error("single byte operand cycle wrong");
  chk_load16_pair: assert property (
    grp_q == GRP_LD16 && cyc_q == 4'h4 |-> bus_q.valid_address_strobe ##1
    (bus_q.valid_address_strobe && bus_q.rw && bus_q.addr == $past(bus_q.addr) + 16'h0001))
    else $error("16-bit load pair wrong");
  chk_acc_store: assert property (
    grp_q == GRP_STA && cyc_q == 4'h4 |-> invalid_read ##1
    (valid_write and bus_q.addr == $past(bus_q.addr)))
    else $error("accumulator store wrong");
  chk_rmw_steps: assert property (
    grp_q == GRP_RMW && cyc_q == 4'h4 |-> bus_q.valid_address_strobe && bus_q.rw ##1 invalid_read
    ##1 (valid_write and bus_q.addr == $past(bus_q.addr, 2)))
    else $error("read-modify-write steps wrong");
  chk_test_quiet: assert property (
    grp_q == GRP_TST && cyc_q == 4'h6 |-> !bus_q.valid_address_strobe && !bus_q.rw)
    else $error("test operand wrote memory");
  chk_branch_idle: assert property (
    grp_q == GRP_BR && cyc_q == 4'h3 |->
    (invalid_read and bus_q.addr == op_addr_q + 16'h0002) ##1 invalid_read ##1 new_opcode)
    else $error("branch cycles wrong");
  chk_bsr_shape: assert property (
    grp_q == GRP_BSR && cyc_q == 4'h3 |-> invalid_read ##1 valid_write ##1
    valid_write ##1 invalid_read [*3] ##1 new_opcode)
    else $error("branch to subroutine shape wrong");
  chk_bsr_land: assert property (
    grp_q == GRP_BSR && cyc_q == 4'h8 |-> bus_q.addr == br_tgt ##1 bus_q.addr == $past(br_tgt))
    else $error("branch to subroutine target wrong");
  chk_strobe_role: assert property (
    // only the test operand may drive data with the strobe low
    !bus_q.valid_address_strobe |-> bus_q.role == ROLE_IRRELEVANT && (bus_q.rw || grp_q == GRP_TST))
    else $error("strobe low on meaningful cycle");
endmodule

//--- verif/seq_memory.sv
// partner model: zero-wait memory that honours the valid-address strobe
`timescale 1ns/10ps
module seq_memory
(
  input  wire logic                   clk,
  input  wire seq_pkg::bus_cycle_type bus,
  output logic [7:0]                  data_in
);
  import seq_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end
  // strobe low: no answer; show a changing byte so stale data never looks valid
  always_comb data_in = (bus.valid_address_strobe && bus.rw) ? mem[bus.addr] : ~last_q;
  always @(posedge clk)
  begin
    last_q <= data_in;
    if (bus.valid_address_strobe && !bus.rw)
      mem[bus.addr] <= bus.dout;
  end
endmodule

//--- verif/test_extended_relative_bus_sequencer.sv
// self-checking bench for the extended and relative bus-cycle sequencer
`timescale 1ns/10ps
module test_extended_relative_bus_sequencer;
  import seq_pkg::*;
  logic          SYS_CLK = 1'b0;
  logic          RST_B = 1'b0;
  logic          COND_TRUE = 1'b0;
  logic [7:0]    ACC_DATA = 8'h00;
  logic [15:0]   STACK_PTR = 16'h2000;
  logic [15:0]   INDEX_REG = 16'h0000;
  logic [7:0]    NEW_OPERAND = 8'h00;
  logic [7:0]    DATA_IN;
  bus_cycle_type BUS;
  bus_cycle_type exp_q [$];
  bus_cycle_type e_mon;
  logic [31:0]   seed = 32'h775bf54f;
  logic [31:0]   r;
  logic [15:0]   pc;
  logic [15:0]   a;
  logic [3:0]    g;
  int            mismatches = 0;
  int            n_compared = 0;
  int            guard;

  extended_relative_bus_sequencer i_extended_relative_bus_sequencer
  (
    .SYS_CLK     (SYS_CLK),
    .RST_B       (RST_B),
    .DATA_IN     (DATA_IN),
    .COND_TRUE   (COND_TRUE),
    .ACC_DATA    (ACC_DATA),
    .STACK_PTR   (STACK_PTR),
    .INDEX_REG   (INDEX_REG),
    .NEW_OPERAND (NEW_OPERAND),
    .BUS         (BUS)
  );
  seq_memory i_seq_memory (.clk(SYS_CLK), .bus(BUS), .data_in(DATA_IN));

  initial
  begin
    forever #50 SYS_CLK = ~SYS_CLK;
  end

  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task cmp(input logic [18:0] got, input logic [18:0] want);
    n_compared++;
    if (got !== want)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task put(input logic [15:0] ad, input logic v, input logic rw, input logic [7:0] d);
    bus_cycle_type c;
    c = '0;
    c.addr = ad;
    c.valid_address_strobe = v;
    c.rw = rw;
    c.dout = d;
    exp_q.push_back(c);
  endtask

  // lays one instruction into memory and notes its bus cycles
  task ins(input logic [7:0] op, input logic [15:0] e);
    logic [15:0] p;
    logic [15:0] t;
    logic [15:0] x;
    logic [15:0] q;
    p = pc;
    t = p + 16'h0002 + {{8{e[7]}}, e[7:0]};
    x = op[0] ? INDEX_REG : STACK_PTR;
    q = (op[7:4] == 4'h9) ? p + 16'h0002 : p + 16'h0003;
    i_seq_memory.mem[p] = op;
    put(p, 1'b1, 1'b1, 8'h00);
    pc = p + 16'h0001;
    if (op[7:4] < 4'h8)
    begin
      i_seq_memory.mem[p + 16'h0001] = e[15:8];
      i_seq_memory.mem[p + 16'h0002] = e[7:0];
      put(p + 16'h0001, 1'b1, 1'b1, 8'h00);
      put(p + 16'h0002, 1'b1, 1'b1, 8'h00);
      pc = p + 16'h0003;
    end
    else if (op[7:4] < 4'ha)
    begin
      i_seq_memory.mem[p + 16'h0001] = e[7:0];
      put(p + 16'h0001, 1'b1, 1'b1, 8'h00);
      put(p + 16'h0002, 1'b0, 1'b1, 8'h00);
    end
    case (op[7:4])
      4'h0: put(e, 1'b1, 1'b1, 8'h00);
      4'h1:
      begin
        put(e, 1'b1, 1'b1, 8'h00);
        put(e + 16'h0001, 1'b1, 1'b1, 8'h00);
      end
      4'h2:
      begin
        put(e, 1'b0, 1'b1, 8'h00);
        put(e, 1'b1, 1'b0, ACC_DATA);
      end
      4'h3:
      begin
        put(e, 1'b0, 1'b1, 8'h00);
        put(e, 1'b1, 1'b0, x[15:8]);
        put(e + 16'h0001, 1'b1, 1'b0, x[7:0]);
      end
      4'h4, 4'h5:
      begin
        put(e, 1'b1, 1'b1, 8'h00);
        put(e, 1'b0, 1'b1, 8'h00);
        put(e, !op[4], 1'b0, NEW_OPERAND);
      end
      4'h6: pc = e;
      4'h7, 4'h9:
      begin
        if (op[7:4] == 4'h7)
          put(e, 1'b1, 1'b1, 8'h00);
        put(STACK_PTR, 1'b1, 1'b0, q[7:0]);
        put(STACK_PTR - 16'h0001, 1'b1, 1'b0, q[15:8]);
        put(STACK_PTR - 16'h0002, 1'b0, 1'b1, 8'h00);
        put(p + 16'h0002, 1'b0, 1'b1, 8'h00);
        put(op[4] && op[7] ? t : p + 16'h0002, op[7:4] == 4'h7, 1'b1, 8'h00);
        pc = op[7] ? t : e;
      end
      4'h8:
      begin
        put(t, 1'b0, 1'b1, 8'h00);
        pc = (op[3:0] == 4'h0 || COND_TRUE) ? t : p + 16'h0002;
      end
      default: ;
    endcase
  endtask

  task restart(input int hold);
    @(posedge SYS_CLK);
    RST_B <= 1'b0;
    repeat (hold) @(posedge SYS_CLK);
    #1;
    cmp({BUS.addr, BUS.valid_address_strobe, BUS.rw, BUS.doe}, {16'h0000, 3'b110});
    exp_q.delete();
  endtask

  always @(negedge SYS_CLK)
  begin
    if (RST_B === 1'b1 && exp_q.size() > 0)
    begin
      e_mon = exp_q.pop_front();
      cmp({BUS.addr, BUS.valid_address_strobe, BUS.rw, BUS.doe}, {e_mon.addr, e_mon.valid_address_strobe, e_mon.rw, !e_mon.rw});
      if (e_mon.valid_address_strobe && !e_mon.rw)
        cmp({11'h000, BUS.dout}, {11'h000, e_mon.dout});
      if (!e_mon.valid_address_strobe)
        cmp({15'h0000, BUS.role}, {15'h0000, ROLE_IRRELEVANT});
    end
  end

  initial
  begin
    for (int k = 0; k < 6; k++)
    begin
      restart(5);
      @(posedge SYS_CLK);
      r = xs();
      STACK_PTR <= {8'h20, r[7:0]};
      INDEX_REG <= r[31:16];
      ACC_DATA <= r[15:8];
      NEW_OPERAND <= r[23:16];
      COND_TRUE <= r[8];
      #1;
      pc = 16'h0000;
      // every group, once with low nibble zero and once random
      for (int j = 0; j < 32; j++)
      begin
        r = xs();
        g = j[3:0];
        if (g < 4'h6)
          a = {2'b01, r[13:0]};
        else if (g < 4'h8)
          a = pc + 16'h0003 + {12'h000, r[3:0]};
        else
          a = {11'h000, r[4:0]};
        ins({g, j[4] ? r[19:16] : 4'h0}, a);
      end
      @(posedge SYS_CLK);
      RST_B <= 1'b1;
      guard = 0;
      // next to last round is cut short by a reset in mid-program
      while (exp_q.size() > ((k == 4) ? 40 : 0) && guard < 3000)
      begin
        @(posedge SYS_CLK);
        guard++;
      end
      if (guard >= 3000)
      begin
        mismatches++;
        break;
      end
    end
    restart(3);
    tally_and_finish();
  end
endmodule
